// [design/fmld_top.sv]
// Purpose: modulator and lock detect configuration registers
// Assumes: register writes and events come from same-clock serial logic
// Notes:   runs on the phase-detector clock
`timescale 1ns/1ps
`default_nettype none
module fmld_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // register port from serial logic
    input  wire logic        reg_wr,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [23:0] reg_wdata,
    output logic      [23:0] reg_rdata_q,
    // synthesizer events
    input  wire logic        freq_change,
    input  wire logic        int_written,
    input  wire logic        frac_written,
    // modulator path
    input  wire logic [3:0]  mod_step,
    output logic      [3:0]  div_frac_step_q,
    output logic      [23:0] mod_seed_q,
    output logic             mod_seed_load_q,
    output logic             mod_clk_en_q,
    output logic             cal_start_q,
    // lock detection
    input  wire logic        cmp_valid,
    input  wire logic        dig_in_window,
    input  wire logic        analog_in_window,
    output logic             oneshot_sel_q,
    output logic             lock_q
);
    logic        rst_s1_q;
    logic        rst_n;
    logic [23:0] mod_cfg_q;
    logic [23:0] lock_ctrl_q;
    logic        ana_s1_q;
    logic        ana_s2_q;
    logic        wr_mod;
    logic        wr_lock;
    logic        core_en;
    logic        bypass;
    logic        seed_load;
    logic [1:0]  seed_code;
    logic [23:0] seed_val;
    logic [2:0]  run_code;
    logic [16:0] run_target;
    logic        win_digital;
    logic        in_window;
    logic        cal_start;
    logic [23:0] rdata;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // analog one-shot result is asynchronous to core_clk
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ana_s1_q <= 1'b0;
            ana_s2_q <= 1'b0;
        end else begin
            ana_s1_q <= analog_in_window;
            ana_s2_q <= ana_s1_q;
        end
    end

    assign wr_mod  = reg_wr && reg_addr == fmld_pkg::ADDR_MOD_CFG;
    assign wr_lock = reg_wr && reg_addr == fmld_pkg::ADDR_LOCK_CTRL;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_cfg_q   <= fmld_pkg::MOD_CFG_RESET;
            lock_ctrl_q <= fmld_pkg::LOCK_RESET;
        end else begin
            if (wr_mod)
                mod_cfg_q <= reg_wdata;
            if (wr_lock)
                lock_ctrl_q <= reg_wdata;
        end
    end

    // field decode
    assign core_en   = mod_cfg_q[fmld_pkg::CORE_EN_BIT];
    assign bypass    = mod_cfg_q[fmld_pkg::BYPASS_BIT];
    assign seed_code = mod_cfg_q[fmld_pkg::SEED_LSB +: 2];
    assign run_code  = lock_ctrl_q[fmld_pkg::RUN_SEL_LSB +: 3];
    assign win_digital = lock_ctrl_q[fmld_pkg::WIN_TYPE_BIT];

    assign seed_val = (seed_code == 2'h0) ? fmld_pkg::SEED_ZERO :
                      (seed_code == 2'h1) ? fmld_pkg::SEED_LSB_V :
                      (seed_code == 2'h2) ? fmld_pkg::SEED_PAT_A :
                                            fmld_pkg::SEED_PAT_B;
    // held seed reaches the modulator only on a qualified frequency change
    assign seed_load = freq_change &&
                       mod_cfg_q[fmld_pkg::INIT_LOAD_BIT];

    // calibration trigger follows the core enable
    assign cal_start = core_en ? frac_written : int_written;

    assign run_target = (run_code == 3'h0) ? fmld_pkg::RUN_0 :
                        (run_code == 3'h1) ? fmld_pkg::RUN_1 :
                        (run_code == 3'h2) ? fmld_pkg::RUN_2 :
                        (run_code == 3'h3) ? fmld_pkg::RUN_3 :
                        (run_code == 3'h4) ? fmld_pkg::RUN_4 :
                        (run_code == 3'h5) ? fmld_pkg::RUN_5 :
                        (run_code == 3'h6) ? fmld_pkg::RUN_6 :
                                             fmld_pkg::RUN_7;
    assign in_window = win_digital ? dig_in_window : ana_s2_q;

    assign rdata = (reg_addr == fmld_pkg::ADDR_MOD_CFG) ? mod_cfg_q :
                   (reg_addr == fmld_pkg::ADDR_LOCK_CTRL) ? lock_ctrl_q :
                   24'h000000;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_seed_q      <= fmld_pkg::SEED_PAT_A;
            mod_seed_load_q <= 1'b0;
            div_frac_step_q <= 4'h0;
            mod_clk_en_q    <= 1'b0;
            cal_start_q     <= 1'b0;
            oneshot_sel_q   <= 1'b0;
            reg_rdata_q     <= 24'h000000;
        end else begin
            if (seed_load)
                mod_seed_q <= seed_val;
            mod_seed_load_q <= seed_load;
            // bypassed output is dropped but the core keeps clocking
            div_frac_step_q <= bypass ? 4'h0 : mod_step;
            mod_clk_en_q    <= core_en;
            cal_start_q     <= cal_start;
            oneshot_sel_q   <= !win_digital;
            reg_rdata_q     <= rdata;
        end
    end

    fmld_lock_run u_run (
        .clk           (core_clk),
        .rst_n         (rst_n),
        .enable        (lock_ctrl_q[fmld_pkg::LD_EN_BIT]),
        .target        (run_target),
        .cmp_valid     (cmp_valid),
        .cmp_in_window (in_window),
        .locked_q      (lock_q)
    );

    AST_SEED_LOAD: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        seed_load |=> mod_seed_q == $past(seed_val) && mod_seed_load_q)
        else $error("seed not loaded on frequency change");
    AST_SEED_HOLD: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !seed_load |=> $stable(mod_seed_q))
        else $error("seed changed without qualified frequency change");
    AST_SEED_PAT: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        seed_load && seed_code == 2'h3 |=> mod_seed_q == fmld_pkg::SEED_PAT_B)
        else $error("wrong pattern for seed code 3");
    AST_BYPASS: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bypass |=> div_frac_step_q == 4'h0 && mod_clk_en_q == $past(core_en))
        else $error("modulator output used while bypassed");
    AST_CAL_FRAC: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        core_en && frac_written && !int_written |=> cal_start_q)
        else $error("calibration missed on fraction write");
    AST_CAL_INT: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !core_en && !int_written |=> !cal_start_q)
        else $error("calibration without integer write");
    AST_CORE_EN: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !core_en ##1 !core_en |-> !mod_clk_en_q)
        else $error("fractional core clocked while disabled");
    AST_MOD_RESET: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(rst_n) |-> mod_cfg_q == fmld_pkg::MOD_CFG_RESET)
        else $error("modulator register default wrong");
    AST_LOCK_RESET: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(rst_n) |-> lock_ctrl_q == fmld_pkg::LOCK_RESET)
        else $error("lock detect register default wrong");
    AST_WIN_SEL: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        win_digital |=> !oneshot_sel_q)
        else $error("one-shot chosen with digital window type");
endmodule // fmld_top
`default_nettype wire

// [design/fmld_pkg.sv]
// Purpose: constants for modulator and lock detect configuration
// Assumes: 24-bit registers, written by the serial port logic
// Notes:   shared by the top and the testbench
// Functional notes
// - two-bit seed code picks zero, LSB, or one of two fixed 24-bit seeds
// - written seed is held; loaded only on frequency change with bit 8 set
// - bypass drops modulator output; core stays clocked while enabled
// - core enable set: calibrate on fraction write; clear: on integer write
// - core enable clear disables fractional core; set (default) enables it
// - lock after a run of in-window counts; code 0..7 maps to run lengths
// - lock detect register bit enables internal detector, default on
// - window-type bit picks digital timer when 1, the default
// - window-type 0 uses analog one-shot of about 10 ns
// - modulator register resets to its default pattern
// - lock detect register resets to its default pattern
`default_nettype none
package fmld_pkg;
    localparam logic [4:0]  ADDR_MOD_CFG   = 5'h06;
    localparam logic [4:0]  ADDR_LOCK_CTRL = 5'h07;
    localparam logic [23:0] MOD_CFG_RESET  = 24'h200B4A;
    localparam logic [23:0] LOCK_RESET     = 24'h00014D;
    // modulator configuration fields
    localparam int SEED_LSB      = 0;
    localparam int BYPASS_BIT    = 7;
    localparam int INIT_LOAD_BIT = 8;
    localparam int CORE_EN_BIT   = 11;
    // lock detect fields
    localparam int RUN_SEL_LSB   = 0;
    localparam int LD_EN_BIT     = 3;
    localparam int WIN_TYPE_BIT  = 6;
    // seed patterns
    localparam logic [23:0] SEED_ZERO = 24'h000000;
    localparam logic [23:0] SEED_LSB_V = 24'h000001;
    localparam logic [23:0] SEED_PAT_A = 24'hB29D08;
    localparam logic [23:0] SEED_PAT_B = 24'h50F1CD;
    // run lengths for codes 0..7
    localparam logic [16:0] RUN_0 = 17'h00005;
    localparam logic [16:0] RUN_1 = 17'h00020;
    localparam logic [16:0] RUN_2 = 17'h00060;
    localparam logic [16:0] RUN_3 = 17'h00100;
    localparam logic [16:0] RUN_4 = 17'h00200;
    localparam logic [16:0] RUN_5 = 17'h00800;
    localparam logic [16:0] RUN_6 = 17'h02000;
    localparam logic [16:0] RUN_7 = 17'h0FFFF;
    // analog one-shot window, for reference by the analog path
    localparam int CLK_PERIOD_NS = 10;
    localparam int ONESHOT_NS    = 10;
    localparam int ONESHOT_CYC   = (ONESHOT_NS / CLK_PERIOD_NS < 1) ? 1
                                   : ONESHOT_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// [design/fmld_lock_run.sv]
// Purpose: consecutive in-window run counter for lock detection
// Assumes: one comparison result per cmp_valid pulse
// Notes:   counter saturates at target so lock holds while in window
`timescale 1ns/1ps
`default_nettype none
module fmld_lock_run (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        enable,
    input  wire logic [16:0] target,
    // comparisons
    input  wire logic        cmp_valid,
    input  wire logic        cmp_in_window,
    // result
    output logic             locked_q
);
    logic [16:0] cnt_q;
    logic [16:0] cnt_d;
    logic        hit;
    logic        miss;

    assign hit  = enable && cmp_valid && cmp_in_window;
    assign miss = enable && cmp_valid && !cmp_in_window;
    assign cnt_d = !enable ? 17'h00000 :
                   miss ? 17'h00000 :
                   (hit && cnt_q < target) ? cnt_q + 17'h00001 : cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q    <= 17'h00000;
            locked_q <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            locked_q <= enable && (cnt_d >= target);
        end
    end

    AST_MISS_DROPS: assert property (
        @(posedge clk) disable iff (!rst_n)
        miss |=> !locked_q && cnt_q == 17'h00000)
        else $error("lock held after out-of-window count");
    AST_RUN_REACHED: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(locked_q) |-> cnt_q == target && $past(hit))
        else $error("lock declared before run length reached");
    AST_DISABLED: assert property (
        @(posedge clk) disable iff (!rst_n)
        !enable |=> !locked_q)
        else $error("lock shown while detector disabled");
endmodule // fmld_lock_run
`default_nettype wire

// [tb/fmld_host_model.sv]
// Purpose: host side of the register port
// Assumes: one word per write, driven on the falling edge
// Notes:   only host obligations are modelled
`timescale 1ns/1ps
`default_nettype none
module fmld_host_model (
    // clock
    input  wire logic        core_clk,
    // register port
    output logic             reg_wr,
    output logic      [4:0]  reg_addr,
    output logic      [23:0] reg_wdata,
    input  wire logic [23:0] reg_rdata_q
);
    initial begin
        reg_wr    = 1'b0;
        reg_addr  = 5'h00;
        reg_wdata = 24'h000000;
    end
    // data inverted after the taking edge so stale values never match
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(negedge core_clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [23:0] d);
        @(negedge core_clk);
        reg_addr = a;
        @(negedge core_clk);
        d = reg_rdata_q;
    endtask
    // fractional: bypass clear, init all ones, auto clock clear
    function automatic logic [23:0] frac_cfg(input logic [1:0] s);
        return 24'h000F48 | {22'h0, s};
    endfunction
    function automatic logic [23:0] int_cfg(input logic [1:0] s);
        return 24'h0007C8 | {22'h0, s};
    endfunction
endmodule // fmld_host_model
`default_nettype wire

// [tb/testbench.sv]
// Purpose: self-checking bench for the configuration block
// Assumes: inputs change on the falling edge
// Notes:   lock codes above 3 skipped to keep the run short
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        core_clk, nrst, reg_wr, freq_change;
    logic        int_written, frac_written, cmp_valid;
    logic        dig_in_window, analog_in_window;
    logic        mod_seed_load_q, mod_clk_en_q, cal_start_q;
    logic        oneshot_sel_q, lock_q;
    logic [4:0]  reg_addr;
    logic [23:0] reg_wdata, reg_rdata_q, mod_seed_q, rd, got;
    logic [3:0]  mod_step, div_frac_step_q;
    integer      seed = 32'had7a;
    int          mismatches = 0;
    int          check_count = 0;
    int          lens [8] = '{5, 32, 96, 256, 512, 2048, 8192, 65535};
    logic [23:0] seeds [4] = '{fmld_pkg::SEED_ZERO, fmld_pkg::SEED_LSB_V,
                               fmld_pkg::SEED_PAT_A, fmld_pkg::SEED_PAT_B};

    fmld_top DUT (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .freq_change(freq_change),
        .int_written(int_written), .frac_written(frac_written),
        .mod_step(mod_step), .div_frac_step_q(div_frac_step_q),
        .mod_seed_q(mod_seed_q), .mod_seed_load_q(mod_seed_load_q),
        .mod_clk_en_q(mod_clk_en_q), .cal_start_q(cal_start_q),
        .cmp_valid(cmp_valid), .dig_in_window(dig_in_window),
        .analog_in_window(analog_in_window),
        .oneshot_sel_q(oneshot_sel_q), .lock_q(lock_q));
    fmld_host_model host (.core_clk(core_clk), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic tick;
        @(negedge core_clk);
    endtask
    // n valid comparisons in a row; the caller holds the window input
    task automatic run(input int n);
        cmp_valid = 1'b1;
        repeat (n) tick();
    endtask
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    initial begin
        {nrst, reg_wr, freq_change, int_written, frac_written} = '0;
        {cmp_valid, dig_in_window, analog_in_window, mod_step} = '0;
        repeat (2) @(posedge core_clk);
        tick();
        nrst = 1'b1;
        repeat (3) tick();
        chk(mod_seed_q, fmld_pkg::SEED_PAT_A);
        host.rd(5'h06, rd);
        chk(rd, 24'h200B4A);
        host.rd(5'h07, rd);
        chk(rd, 24'h00014D);
        host.rd(5'h1A, rd);
        chk(rd, 24'h0);
        for (int c = 0; c < 4; c++) begin
            host.wr(5'h06, host.frac_cfg(c[1:0]));
            freq_change = 1'b1;
            tick();
            freq_change = 1'b0;
            chk(mod_seed_q, seeds[c]);
            chk(mod_seed_load_q, 24'h1);
            tick();
            chk(mod_seed_load_q, 24'h0);
        end
        host.wr(5'h06, 24'h000848); // init field clear: no load
        freq_change = 1'b1;
        tick();
        freq_change = 1'b0;
        chk(mod_seed_load_q, 24'h0);
        chk(mod_seed_q, fmld_pkg::SEED_PAT_B);
        for (int m = 0; m < 2; m++) begin
            host.wr(5'h06, m ? host.int_cfg(0) : host.frac_cfg(0));
            repeat (4) begin
                mod_step = $random(seed);
                tick();
                chk(div_frac_step_q, m ? 4'h0 : mod_step);
            end
            chk(mod_clk_en_q, m ? 24'h0 : 24'h1);
            frac_written = 1'b1;
            tick();
            frac_written = 1'b0;
            chk(cal_start_q, m ? 24'h0 : 24'h1);
            int_written = 1'b1;
            tick();
            int_written = 1'b0;
            chk(cal_start_q, m ? 24'h1 : 24'h0);
        end
        dig_in_window = 1'b1;
        for (int c = 0; c < 4; c++) begin
            host.wr(5'h07, 24'h000048 | c);
            // select flop follows the register one edge later
            tick();
            chk(oneshot_sel_q, 24'h0);
            run(lens[c] - 1);
            chk(lock_q, 24'h0);
            tick();
            chk(lock_q, 24'h1);
            dig_in_window = 1'b0;
            tick();
            dig_in_window = 1'b1;
            cmp_valid = 1'b0;
            chk(lock_q, 24'h0);
        end
        host.wr(5'h07, 24'h000040);
        run(8);
        chk(lock_q, 24'h0);
        cmp_valid = 1'b0;
        dig_in_window = 1'b0;
        analog_in_window = 1'b1;
        host.wr(5'h07, 24'h000008);
        tick();
        chk(oneshot_sel_q, 24'h1);
        run(4);
        chk(lock_q, 24'h0);
        for (int i = 0; i < 8 && lock_q !== 1'b1; i++) tick();
        chk(lock_q, 24'h1);
        cmp_valid = 1'b0;
        rd = $random(seed);
        host.wr(5'h07, rd);
        host.wr(5'h10 | ($random(seed) & 5'h0F), ~rd);
        host.rd(5'h07, got);
        chk(got, rd);
        conclude();
    end
endmodule // testbench
`default_nettype wire
